// File: adcdc_top.sv
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
module adcdc_top (
	input wire logic core_clk_i,               // Core clock, 25 MHz
	input wire logic nrst_i,                   // Async reset, active low
	input wire logic [4:0] avs_address_i,      // Avalon byte address
	input wire logic avs_read_i,               // Avalon read request
	input wire logic avs_write_i,              // Avalon write request
	input wire logic [31:0] avs_writedata_i,   // Avalon write data
	output logic [31:0] avs_readdata_o,        // Avalon read data
	output logic avs_waitrequest_o,            // Avalon wait request
	input wire logic [3:0] ch0_thermo_i,       // Channel 0 comparators, thermometer code
	input wire logic [3:0] ch1_thermo_i,       // Channel 1 comparators, thermometer code
	output logic sample_clock_o,               // Modulator sample clock
	output logic sample_ready_strobe_n_o       // Word ready pulse, active low
);
	typedef struct packed {
		logic [2:0] oversampling_ratio;
		logic [1:0] pre;
		logic [23:0] off0;
		logic [23:0] gain0;
		logic [23:0] off1;
		logic [23:0] gain1;
		logic ack;
		logic [31:0] rdata;
		logic overrun;
		logic [4:0] div_cnt;
		logic sclk;
		logic [11:0] smp_cnt;
		logic [15:0] acc0;
		logic [15:0] acc1;
		logic pend_valid;
		logic [47:0] pend_data;
		logic drdy_n;
		logic [3:0] sync0_a;
		logic [3:0] sync0_b;
		logic [3:0] sync1_a;
		logic [3:0] sync1_b;
	} adcdc_st_t;

	adcdc_st_t st_r;
	adcdc_st_t st_nxt;

	adcdc_stream_if #(.W(adcdc_pkg::FIFO_W)) fill_if ();
	adcdc_stream_if #(.W(adcdc_pkg::FIFO_W)) drain_if ();
	logic [3:0] fifo_count;

	logic req;
	logic take;
	logic tick;
	logic last_smp;
	logic [4:0] div_last;
	logic [11:0] osr_last;
	logic [2:0] lvl0;
	logic [2:0] lvl1;
	logic [15:0] sum0;
	logic [15:0] sum1;
	logic [23:0] word0;
	logic [23:0] word1;
	logic pop_rd;

	// Ratio selected by the three-bit field, minus one
	function automatic logic [11:0] osr_minus_one(input logic [2:0] code);
		logic [12:0] ratio;
		ratio = 13'h0020 << code;
		return 12'(ratio - 13'h0001);
	endfunction

	// Number of set comparator bits gives the quantizer level 0..4
	function automatic logic [2:0] thermo_level(input logic [3:0] t);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 4; i++) begin
			n = n + {2'h0, t[i]};
		end
		return n;
	endfunction

	// Centred quantizer value -2..+2 sign extended to the accumulator width
	function automatic logic [15:0] level_value(input logic [2:0] lvl);
		logic [2:0] d;
		d = lvl - adcdc_pkg::QUANT_MID;
		return {{13{d[2]}}, d};
	endfunction

	// Scale the decimated sum, add offset, apply gain, saturate
	function automatic logic [23:0] correct(
		input logic [15:0] sum,
		input logic [2:0] code,
		input logic [23:0] off,
		input logic [23:0] gain
	);
		logic signed [51:0] x;
		logic signed [51:0] y;
		logic signed [51:0] p;
		logic signed [51:0] z;
		logic [5:0] sh;
		x = 52'(signed'(sum));
		sh = 6'(adcdc_pkg::SHIFT_BASE) - {3'h0, code};
		x = x <<< sh;
		y = x + 52'(signed'(off));
		p = y * 52'(signed'(gain));
		z = y + (p >>> adcdc_pkg::GAIN_FRAC);
		if (z > 52'(signed'(adcdc_pkg::WORD_MAX))) begin
			return adcdc_pkg::WORD_MAX;
		end else if (z < 52'(signed'(adcdc_pkg::WORD_MIN))) begin
			return adcdc_pkg::WORD_MIN;
		end else begin
			return z[23:0];
		end
	endfunction

	adcdc_fifo #(
		.WIDTH(adcdc_pkg::FIFO_W),
		.DEPTH(adcdc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.wr(fill_if.snk),
		.rd(drain_if.src),
		.count_o(fifo_count)
	);

	// One wait cycle on every access, then the answer
	assign req = avs_read_i || avs_write_i;
	assign take = req && st_r.ack;
	assign avs_waitrequest_o = req && !st_r.ack;
	assign avs_readdata_o = st_r.rdata;
	assign sample_clock_o = st_r.sclk;
	assign sample_ready_strobe_n_o = st_r.drdy_n;

	// Sample clock period is 4 * 2^pre core cycles
	assign div_last = 5'((adcdc_pkg::SAMPLE_DIV << st_r.pre) - 1);
	assign tick = (st_r.div_cnt == div_last);
	assign osr_last = osr_minus_one(st_r.oversampling_ratio);
	assign last_smp = tick && (st_r.smp_cnt == osr_last);

	assign lvl0 = thermo_level(st_r.sync0_b);
	assign lvl1 = thermo_level(st_r.sync1_b);
	assign sum0 = st_r.acc0 + level_value(lvl0);
	assign sum1 = st_r.acc1 + level_value(lvl1);
	assign word0 = correct(sum0, st_r.oversampling_ratio, st_r.off0, st_r.gain0);
	assign word1 = correct(sum1, st_r.oversampling_ratio, st_r.off1, st_r.gain1);

	assign fill_if.valid = st_r.pend_valid;
	assign fill_if.data = st_r.pend_data;
	assign pop_rd = take && avs_read_i && (avs_address_i == adcdc_pkg::ADDR_DATA_CH1);
	assign drain_if.ready = pop_rd;

	always_comb begin
		st_nxt = st_r;
		st_nxt.sync0_a = ch0_thermo_i;
		st_nxt.sync0_b = st_r.sync0_a;
		st_nxt.sync1_a = ch1_thermo_i;
		st_nxt.sync1_b = st_r.sync1_a;
		st_nxt.ack = req && !st_r.ack;
		st_nxt.drdy_n = 1'b1;

		// Sample clock divider, high for the first half of each period
		st_nxt.div_cnt = tick ? '0 : st_r.div_cnt + 1'b1;
		// Compare against half of the last count so the /8 prescale does not overflow five bits
		st_nxt.sclk = (st_nxt.div_cnt <= (div_last >> 1));

		// Decimation: integrate one quantizer level per sample
		if (tick) begin
			if (last_smp) begin
				st_nxt.smp_cnt = '0;
				st_nxt.acc0 = '0;
				st_nxt.acc1 = '0;
			end else begin
				st_nxt.smp_cnt = st_r.smp_cnt + 1'b1;
				st_nxt.acc0 = sum0;
				st_nxt.acc1 = sum1;
			end
		end

		// Hand the finished pair to the FIFO; a full FIFO holds it back
		if (st_r.pend_valid && fill_if.ready) begin
			st_nxt.pend_valid = 1'b0;
		end
		if (last_smp) begin
			st_nxt.drdy_n = 1'b0;
			if (st_r.pend_valid && !fill_if.ready) begin
				st_nxt.overrun = 1'b1;
			end else begin
				st_nxt.pend_valid = 1'b1;
				st_nxt.pend_data = {word1, word0};
			end
		end

		// Register reads, answered one cycle after the request
		if (req && !st_r.ack) begin
			st_nxt.rdata = 32'h00000000;
			if (avs_read_i) begin
				if (avs_address_i == adcdc_pkg::ADDR_CONFIG) begin
					st_nxt.rdata[adcdc_pkg::CFG_OSR_LSB +: 3] = st_r.oversampling_ratio;
					st_nxt.rdata[adcdc_pkg::CFG_PRE_LSB +: 2] = st_r.pre;
				end else if (avs_address_i == adcdc_pkg::ADDR_OFFSET_CH0) begin
					st_nxt.rdata[23:0] = st_r.off0;
				end else if (avs_address_i == adcdc_pkg::ADDR_GAIN_CH0) begin
					st_nxt.rdata[23:0] = st_r.gain0;
				end else if (avs_address_i == adcdc_pkg::ADDR_OFFSET_CH1) begin
					st_nxt.rdata[23:0] = st_r.off1;
				end else if (avs_address_i == adcdc_pkg::ADDR_GAIN_CH1) begin
					st_nxt.rdata[23:0] = st_r.gain1;
				end else if (avs_address_i == adcdc_pkg::ADDR_STATUS) begin
					st_nxt.rdata[adcdc_pkg::STAT_VALID_BIT] = drain_if.valid;
					st_nxt.rdata[adcdc_pkg::STAT_COUNT_LSB +: 4] = fifo_count;
					st_nxt.rdata[adcdc_pkg::STAT_OVERRUN_BIT] = st_r.overrun;
				end else if (avs_address_i == adcdc_pkg::ADDR_DATA_CH0) begin
					st_nxt.rdata[23:0] = drain_if.valid ? drain_if.data[23:0] : 24'h000000;
				end else if (avs_address_i == adcdc_pkg::ADDR_DATA_CH1) begin
					st_nxt.rdata[23:0] = drain_if.valid ? drain_if.data[47:24] : 24'h000000;
				end
			end
		end

		// Register writes take effect on the answering edge
		if (take && avs_write_i) begin
			if (avs_address_i == adcdc_pkg::ADDR_CONFIG) begin
				st_nxt.oversampling_ratio = avs_writedata_i[adcdc_pkg::CFG_OSR_LSB +: 3];
				st_nxt.pre = avs_writedata_i[adcdc_pkg::CFG_PRE_LSB +: 2];
				// Restart the frame so a new ratio never sees a stale count
				st_nxt.div_cnt = '0;
				st_nxt.smp_cnt = '0;
				st_nxt.acc0 = '0;
				st_nxt.acc1 = '0;
			end else if (avs_address_i == adcdc_pkg::ADDR_OFFSET_CH0) begin
				st_nxt.off0 = avs_writedata_i[23:0];
			end else if (avs_address_i == adcdc_pkg::ADDR_GAIN_CH0) begin
				st_nxt.gain0 = avs_writedata_i[23:0];
			end else if (avs_address_i == adcdc_pkg::ADDR_OFFSET_CH1) begin
				st_nxt.off1 = avs_writedata_i[23:0];
			end else if (avs_address_i == adcdc_pkg::ADDR_GAIN_CH1) begin
				st_nxt.gain1 = avs_writedata_i[23:0];
			end else if (avs_address_i == adcdc_pkg::ADDR_STATUS) begin
				// Write one clears; a new overrun in the same cycle wins
				if (avs_writedata_i[adcdc_pkg::STAT_OVERRUN_BIT] && !(last_smp
						&& st_r.pend_valid && !fill_if.ready)) begin
					st_nxt.overrun = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
			st_r.oversampling_ratio <= adcdc_pkg::OSR_RESET;
			st_r.pre <= adcdc_pkg::PRE_RESET;
			st_r.drdy_n <= 1'b1;
			st_r.sclk <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// File: adcdc_pkg.sv
package adcdc_pkg;
	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] ADDR_CONFIG = 5'h00;
	localparam logic [4:0] ADDR_OFFSET_CH0 = 5'h04;
	localparam logic [4:0] ADDR_GAIN_CH0 = 5'h08;
	localparam logic [4:0] ADDR_OFFSET_CH1 = 5'h0C;
	localparam logic [4:0] ADDR_GAIN_CH1 = 5'h10;
	localparam logic [4:0] ADDR_STATUS = 5'h14;
	localparam logic [4:0] ADDR_DATA_CH0 = 5'h18;
	localparam logic [4:0] ADDR_DATA_CH1 = 5'h1C;

	// Configuration register fields
	localparam int CFG_OSR_LSB = 0;
	localparam int CFG_PRE_LSB = 4;
	localparam logic [2:0] OSR_RESET = 3'h3;
	localparam logic [1:0] PRE_RESET = 2'h0;

	// Status register fields
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_COUNT_LSB = 1;
	localparam int STAT_OVERRUN_BIT = 5;

	// Word and datapath widths, FIFO depth
	localparam int WORD_W = 24;
	localparam int ACC_W = 16;
	localparam int SMP_W = 12;
	localparam int DIV_W = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = 2 * WORD_W;

	// Sample clock is the core clock divided by four times the prescale factor
	localparam int SAMPLE_DIV = 4;
	// Gain word is a signed fraction with this many fraction bits
	localparam int GAIN_FRAC = 23;
	// Left shift that brings an OVERSAMPLING_RATIO-long sum to full scale is SHIFT_BASE - osr code
	localparam int SHIFT_BASE = 17;
	// Mid level of the five-level quantizer
	localparam logic [2:0] QUANT_MID = 3'h2;
	localparam logic [23:0] WORD_MAX = 24'h7FFFFF;
	localparam logic [23:0] WORD_MIN = 24'h800000;
endpackage

// File: adcdc_stream_if.sv
`timescale 1ns/1ps
interface adcdc_stream_if #(
	parameter int W = 48
);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// File: adcdc_fifo.sv
`timescale 1ns/1ps
module adcdc_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,           // Core clock
	input wire logic nrst_i,          // Async reset, active low
	adcdc_stream_if.snk wr,           // Filling side
	adcdc_stream_if.src rd,           // Draining side
	output logic [$clog2(DEPTH):0] count_o // Words held
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} adcdc_fifo_st_t;

	adcdc_fifo_st_t st_r;
	adcdc_fifo_st_t st_nxt;
	logic push;
	logic pop;

	assign wr.ready = (st_r.cnt != (AW + 1)'(DEPTH));
	assign rd.valid = (st_r.cnt != '0);
	assign rd.data = st_r.mem[st_r.rp];
	assign count_o = st_r.cnt;
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = wr.data;
			st_nxt.wp = (st_r.wp == LAST) ? '0 : st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == LAST) ? '0 : st_r.rp + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// File: adcdc_mod_model.sv
`timescale 1ns/1ps
module adcdc_mod_model (
	input wire logic sample_clock_i, // Sample clock from block
	input wire logic [2:0] lvl0_i, // Channel 0 ones count
	input wire logic [2:0] lvl1_i, // Channel 1 ones count
	output logic [3:0] th0_o, // Channel 0 comparators
	output logic [3:0] th1_o // Channel 1 comparators
);
	initial begin
		th0_o = 4'h3;
		th1_o = 4'h3;
	end
	// Decisions refresh once per sample period
	always @(posedge sample_clock_i) begin
		th0_o <= 4'((5'h01 << lvl0_i) - 5'h01);
		th1_o <= 4'((5'h01 << lvl1_i) - 5'h01);
	end
endmodule

// File: adcdc_checker.sv
`timescale 1ns/1ps
module adcdc_checker (
	input wire logic core_clk_i, // Clock
	input wire logic nrst_i, // Reset
	input wire logic [4:0] avs_address_i, // Address
	input wire logic avs_read_i, // Read
	input wire logic avs_write_i, // Write
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [31:0] avs_readdata_o, // Read data
	input wire logic avs_waitrequest_o, // Wait
	input wire logic sample_clock_o, // Sample clock
	input wire logic sample_ready_strobe_n_o // Strobe
);
	logic [5:0] cfg_r;
	logic rs_r; // Restart since last strobe
	logic [17:0] cnt_r;
	wire req = avs_read_i || avs_write_i;
	wire rd = avs_read_i && !avs_waitrequest_o;
	wire wc = avs_write_i && !avs_waitrequest_o && avs_address_i == adcdc_pkg::ADDR_CONFIG;
	wire [17:0] per = 18'(128 << cfg_r[2:0] << cfg_r[5:4]);
	wire [31:0] d = avs_readdata_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_r <= 6'h03;
			rs_r <= 1'b1;
			cnt_r <= 18'h0;
		end else begin
			cfg_r <= wc ? {avs_writedata_i[5:4], 1'b0, avs_writedata_i[2:0]} : cfg_r;
			rs_r <= wc || (rs_r && sample_ready_strobe_n_o);
			cnt_r <= sample_ready_strobe_n_o ? cnt_r + 18'h1 : 18'h1;
		end
	end
	sequence one_wait;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	sequence sclk_p0;
		sample_clock_o [*2] ##1 !sample_clock_o [*2];
	endsequence
	AST_ANSWER: assert property (req && !$past(req) |-> one_wait)
		else $error("request not answered after one wait cycle");
	AST_IDLE: assert property (!req |-> !avs_waitrequest_o)
		else $error("waitrequest while idle");
	AST_UNMAPPED: assert property (rd && avs_address_i[1:0] != 2'h0 |-> d == 32'h0)
		else $error("unaligned read not zero");
	AST_CFG_READ: assert property (rd && avs_address_i == 5'h00 |-> d == {26'h0, cfg_r})
		else $error("config readback wrong");
	AST_STATUS: assert property (rd && avs_address_i == adcdc_pkg::ADDR_STATUS |->
		d[31:6] == 26'h0 && d[4:1] <= 4'h8 && d[0] == (d[4:1] != 4'h0))
		else $error("status fields inconsistent");
	AST_STROBE: assert property ($fell(sample_ready_strobe_n_o) |=> sample_ready_strobe_n_o)
		else $error("strobe longer than one cycle");
	AST_RATE: assert property (!sample_ready_strobe_n_o && !rs_r |-> cnt_r == per)
		else $error("word interval wrong");
	AST_SCLK: assert property (disable iff (!nrst_i || rs_r)
		$rose(sample_clock_o) && cfg_r[5:4] == 2'h0 |-> sclk_p0)
		else $error("sample clock shape wrong");
endmodule
bind adcdc_top adcdc_checker adcdc_checker_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .sample_clock_o(sample_clock_o),
	.sample_ready_strobe_n_o(sample_ready_strobe_n_o));

// File: test_adc_decimation_calibration.sv
`timescale 1ns/1ps
module test_adc_decimation_calibration;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [4:0] ad_r = 5'h00;
	logic [31:0] wd_r = 32'h0;
	logic [2:0] l0 = 3'h2;
	logic [2:0] l1 = 3'h2;
	logic [31:0] rdata, q;
	logic wreq, sclk, stb_n;
	logic [3:0] th0, th1;
	int error_cnt = 0;
	int num_checks = 0;
	adcdc_top adcdc_top_i (.core_clk_i(core_clk), .nrst_i(nrst), .avs_address_i(ad_r),
		.avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd_r),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .ch0_thermo_i(th0),
		.ch1_thermo_i(th1), .sample_clock_o(sclk), .sample_ready_strobe_n_o(stb_n));
	adcdc_mod_model adcdc_mod_model_i (.sample_clock_i(sclk), .lvl0_i(l0), .lvl1_i(l1),
		.th0_o(th0), .th1_o(th1));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", s, exp, got);
		end
	endtask
	task hang;
		error_cnt++;
		$display("[FAIL] wait exp done got timeout");
		test_done;
	endtask
	task xf(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		rd_r <= !w;
		wr_r <= w;
		ad_r <= a;
		wd_r <= d;
		// Waitrequest and read data are taken at the same rising edge
		do begin
			@(posedge core_clk);
			if (++n > 20) hang;
		end while (wreq !== 1'b0);
		q = rdata;
		rd_r <= 1'b0;
		wr_r <= 1'b0;
	endtask
	task rc(input logic [4:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask
	task wstb(output int n);
		n = 0;
		do begin
			@(negedge core_clk);
			if (++n > 20000) hang;
		end while (stb_n !== 1'b0);
	endtask
	task rate(input logic [5:0] c);
		int n;
		xf(1'b1, adcdc_pkg::ADDR_CONFIG, {26'h0, c});
		wstb(n);
		wstb(n);
		chk("interval", 32'(n), 32'(128 << c[2:0] << c[5:4]));
	endtask
	task dat(input logic [2:0] v0, v1, input logic [23:0] o0, g0, o1, g1, e0, e1);
		int n;
		logic [23:0] cv[4];
		cv = '{o0, g0, o1, g1};
		l0 <= v0;
		l1 <= v1;
		for (int k = 0; k < 4; k++)
			xf(1'b1, adcdc_pkg::ADDR_OFFSET_CH0 + 5'(4 * k), {8'h0, cv[k]});
		xf(1'b1, adcdc_pkg::ADDR_CONFIG, 32'h0);
		wstb(n);
		repeat (3) @(negedge core_clk);
		xf(1'b0, adcdc_pkg::ADDR_DATA_CH0, 32'h0);
		chk("ch0", {8'h0, q[23:0]}, {8'h0, e0});
		xf(1'b0, adcdc_pkg::ADDR_DATA_CH1, 32'h0);
		chk("ch1", {8'h0, q[23:0]}, {8'h0, e1});
		$display("end data test");
	endtask
	initial begin
		int n;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		xf(1'b1, 5'h02, 32'h37);
		rc(adcdc_pkg::ADDR_CONFIG, 32'h3);
		rc(adcdc_pkg::ADDR_STATUS, 32'h0);
		rc(5'h02, 32'h0);
		$display("end reset test");
		dat(3'h3, 3'h1, 24'h0, 24'h0, 24'h0, 24'h0, 24'h400000, 24'hC00000);
		dat(3'h3, 3'h4, 24'h100, 24'h0, 24'h0, 24'h0, 24'h400100, 24'h7FFFFF);
		dat(3'h3, 3'h0, 24'h100000, 24'h400000, 24'hFFFFFF, 24'h0, 24'h780000, 24'h800000);
		rc(adcdc_pkg::ADDR_OFFSET_CH0, 32'h00100000);
		// Eight queued, one held, one dropped
		for (int i = 0; i < 10; i++)
			wstb(n);
		rc(adcdc_pkg::ADDR_STATUS, 32'h31);
		xf(1'b1, adcdc_pkg::ADDR_CONFIG, 32'h37);
		for (int i = 0; i < 12; i++) begin
			xf(1'b0, adcdc_pkg::ADDR_STATUS, 32'h0);
			if (q[0] === 1'b1)
				xf(1'b0, adcdc_pkg::ADDR_DATA_CH1, 32'h0);
		end
		rc(adcdc_pkg::ADDR_STATUS, 32'h20);
		xf(1'b1, adcdc_pkg::ADDR_STATUS, 32'h20);
		rc(adcdc_pkg::ADDR_STATUS, 32'h0);
		$display("end fifo test");
		for (int i = 0; i < 8; i++)
			rate(6'(i));
		for (int p = 1; p < 4; p++)
			rate(6'(p << 4));
		$display("end rate test");
		test_done;
	end
endmodule
